// ==== rtl/acsm_avs.sv ====
`timescale 1ns/1ps
// avalon handshake: one wait cycle, then the request is taken
module acsm_avs (
  input wire logic sys_clk_i, // system clock
  input wire logic reset_i, // async reset, active high
  input wire logic read_i, // avalon read
  input wire logic write_i, // avalon write
  output logic waitrequest_o, // registered waitrequest
  output logic arm_o, // first cycle of a request
  output logic take_o // request taken this edge
);

  logic wait_r;

  // waitrequest idles high so no request passes unseen
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      wait_r <= 1'b1;
    end else if (wait_r && (read_i || write_i)) begin
      wait_r <= 1'b0;
    end else begin
      wait_r <= 1'b1;
    end
  end

  assign waitrequest_o = wait_r;
  assign arm_o = wait_r && (read_i || write_i);
  assign take_o = !wait_r && (read_i || write_i);

endmodule

// ==== rtl/acsm_mult_check.sv ====
`timescale 1ns/1ps
// judges a requested sectors-per-block count
module acsm_mult_check #(
  parameter int MAX_MULT = 16
) (
  input wire logic [7:0] cnt_i, // requested count
  output logic zero_o, // count is zero
  output logic ok_o // count is supported
);

  localparam logic [7:0] MAX_CNT = 8'(MAX_MULT);

  // only powers of two up to the buffer size are served
  assign zero_o = (cnt_i == 8'h00);
  assign ok_o = !zero_o && ((cnt_i & (cnt_i - 8'h01)) == 8'h00) &&
                (cnt_i <= MAX_CNT);

endmodule

// ==== rtl/acsm_pkg.sv ====
package acsm_pkg;

  ////////////////////////////////////////////////////////////////////////
  // register byte offsets on the avalon slave
  localparam int ADDR_W = 6;
  localparam logic [5:0] OFS_FEATURE = 6'h00;
  localparam logic [5:0] OFS_SECCNT = 6'h04;
  localparam logic [5:0] OFS_SECNUM = 6'h08;
  localparam logic [5:0] OFS_CYL_LO = 6'h0c;
  localparam logic [5:0] OFS_CYL_HI = 6'h10;
  localparam logic [5:0] OFS_DRVHEAD = 6'h14;
  localparam logic [5:0] OFS_COMMAND = 6'h18;
  localparam logic [5:0] OFS_STATUS = 6'h1c;
  localparam logic [5:0] OFS_ERROR = 6'h20;
  localparam logic [5:0] OFS_MAX_LBA = 6'h24;
  localparam logic [5:0] OFS_MULT = 6'h28;
  localparam logic [5:0] OFS_IDENT82 = 6'h2c;

  ////////////////////////////////////////////////////////////////////////
  // command codes and signatures
  localparam logic [7:0] CMD_SET_MAX = 8'hf9;
  localparam logic [7:0] CMD_READ_NATIVE = 8'hf8;
  localparam logic [7:0] CMD_SET_MULT = 8'hc6;
  localparam logic [7:0] CMD_SLEEP_A = 8'h99;
  localparam logic [7:0] CMD_SLEEP_B = 8'he6;
  localparam logic [7:0] CMD_SMART = 8'hb0;
  localparam logic [7:0] SMART_SIG_HI = 8'hc2;
  localparam logic [7:0] SMART_SIG_LO = 8'h4f;
  localparam logic [2:0] SMART_DH_ONES = 3'h7;

  // set-max subfunctions in the feature register
  localparam logic [7:0] SMAX_ADDRESS = 8'h00;
  localparam logic [7:0] SMAX_SET_PW = 8'h01;
  localparam logic [7:0] SMAX_LOCK = 8'h02;
  localparam logic [7:0] SMAX_UNLOCK = 8'h03;
  localparam logic [7:0] SMAX_FREEZE = 8'h04;

  ////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int ST_BSY_BIT = 7;
  localparam int ST_DRDY_BIT = 6;
  localparam int ST_SLEEP_BIT = 5;
  localparam int ST_ERR_BIT = 0;
  localparam int ER_ABRT_BIT = 2;
  localparam int DH_LBA_BIT = 6;
  localparam int KEEP_LIMIT_BIT = 0;
  localparam int IDENT82_SMART_BIT = 0;
  localparam int MULT_EN_BIT = 8;

  // reset values
  localparam logic [7:0] RST_TF = 8'h00;
  localparam logic [7:0] RST_MULT_CNT = 8'h00;
  localparam logic [15:0] RST_PW = 16'h0000;

  typedef enum logic [0:0] {ST_IDLE, ST_EXEC} acsm_state_t;

endpackage

// ==== rtl/acsm_top.sv ====
`timescale 1ns/1ps
// Summary of operation
// - command f9h sets the host-visible maximum sector
// - keep-limit bit one survives hardware reset, not power-on
// - keep-limit zero reverts to stored limit
// - feature selects password, lock, unlock, freeze
// - first nonvolatile set-max after reset aborts
// - c6h sets busy and checks sector count
// - supported count stored, multiple commands enabled
// - unsupported count aborts and disables multiple
// - zero count disables multiple commands
// - multiple mode disabled after power-on
// - 99h or e6h sleeps, interrupt at once
// - any later command wakes the drive
// - smart needs b0h, c2h/4fh signature, 111 head
// - identify word 82 bit 0 reports smart
module acsm_top
  import acsm_pkg::*;
#(
  parameter logic [27:0] NATIVE_MAX = 28'hfffffff,
  parameter int MAX_MULT = 16
) (
  input wire logic sys_clk_i, // 10 mhz system clock
  input wire logic reset_i, // power-on reset, async high
  input wire logic hw_reset_i, // hardware reset pulse, sync
  input wire logic [ADDR_W-1:0] avs_address_i, // byte address
  input wire logic avs_read_i, // avalon read
  input wire logic avs_write_i, // avalon write
  input wire logic [31:0] avs_writedata_i, // write data
  output logic [31:0] avs_readdata_o, // read data
  output logic avs_waitrequest_o, // wait request
  output logic irq_o, // command complete pulse
  output logic sleep_o, // drive in sleep state
  output logic mult_en_o, // multiple transfers enabled
  output logic [7:0] mult_cnt_o, // sectors per block
  output logic [27:0] max_lba_o, // host-visible max sector
  output logic smart_req_o, // smart command pulse
  output logic [7:0] smart_feature_o // smart subfunction
);

  if (MAX_MULT < 1 || MAX_MULT > 128) begin : g_bad_mult
    $error("MAX_MULT must lie in 1..128");
  end

  ////////////////////////////////////////////////////////////////////////
  // bus slave
  logic arm, take;

  acsm_avs u_avs (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .read_i(avs_read_i),
    .write_i(avs_write_i),
    .waitrequest_o(avs_waitrequest_o),
    .arm_o(arm),
    .take_o(take)
  );

  acsm_state_t state_r;
  logic [7:0] feat_r, seccnt_r, secnum_r, cyl_lo_r, cyl_hi_r, dh_r, cmd_r;
  logic abrt_r, prev_native_r, nv_block_r, locked_r, frozen_r;
  logic [27:0] max_r, nv_max_r, req_lba;
  logic [15:0] pw_r;
  logic wr_take, cmd_take, busy, smart_sig, abort_nxt, keep_limit, max_ok;
  logic is_setmax, is_mult, is_sleep, is_smart, is_native, mult_zero, mult_ok;

  acsm_mult_check #(
    .MAX_MULT(MAX_MULT)
  ) u_mult (
    .cnt_i(seccnt_r),
    .zero_o(mult_zero),
    .ok_o(mult_ok)
  );

  assign busy = (state_r == ST_EXEC);
  // host writes to the task file are ignored while a command runs
  assign wr_take = take && avs_write_i && !busy;
  assign cmd_take = wr_take && (avs_address_i == OFS_COMMAND);
  assign req_lba = {dh_r[3:0], cyl_hi_r, cyl_lo_r, secnum_r};
  assign keep_limit = seccnt_r[KEEP_LIMIT_BIT];

  ////////////////////////////////////////////////////////////////////////
  // command decode
  assign is_setmax = (cmd_r == CMD_SET_MAX);
  assign is_native = (cmd_r == CMD_READ_NATIVE);
  assign is_mult = (cmd_r == CMD_SET_MULT);
  assign is_sleep = (cmd_r == CMD_SLEEP_A) || (cmd_r == CMD_SLEEP_B);
  assign is_smart = (cmd_r == CMD_SMART);
  assign smart_sig = (cyl_hi_r == SMART_SIG_HI) &&
                     (cyl_lo_r == SMART_SIG_LO) &&
                     (dh_r[7:5] == SMART_DH_ONES);

  // plain address change: prerequisites, lock, range and lba mode
  assign max_ok = prev_native_r && !locked_r && !frozen_r &&
                  dh_r[DH_LBA_BIT] && (req_lba <= NATIVE_MAX) &&
                  !(keep_limit && nv_block_r);

  // abort decision for the command in execution
  always_comb begin
    abort_nxt = 1'b0;
    if (is_setmax) begin
      unique case (feat_r)
        SMAX_ADDRESS: abort_nxt = !max_ok;
        SMAX_SET_PW: abort_nxt = frozen_r || locked_r;
        SMAX_LOCK: abort_nxt = frozen_r;
        SMAX_UNLOCK: abort_nxt = frozen_r || ({cyl_hi_r, cyl_lo_r} != pw_r);
        SMAX_FREEZE: abort_nxt = 1'b0;
        default: abort_nxt = 1'b1;
      endcase
    end else if (is_mult) begin
      abort_nxt = !mult_zero && !mult_ok;
    end else if (is_smart) begin
      abort_nxt = !smart_sig;
    end else if (!is_native && !is_sleep) begin
      abort_nxt = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // one busy cycle per command, completion pulse as it ends
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_r <= ST_IDLE;
      cmd_r <= RST_TF;
      irq_o <= 1'b0;
    end else begin
      irq_o <= busy;
      state_r <= cmd_take ? ST_EXEC : ST_IDLE;
      if (cmd_take) begin
        cmd_r <= avs_writedata_i[7:0];
      end
    end
  end

  // abort flag: cleared on a new command, set at its end
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      abrt_r <= 1'b0;
    end else if (busy) begin
      abrt_r <= abort_nxt;
    end else if (cmd_take) begin
      abrt_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // task file; read-native returns the native max into it
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      feat_r <= RST_TF;
      seccnt_r <= RST_TF;
      secnum_r <= RST_TF;
      cyl_lo_r <= RST_TF;
      cyl_hi_r <= RST_TF;
      dh_r <= RST_TF;
    end else if (busy && is_native) begin
      secnum_r <= NATIVE_MAX[7:0];
      cyl_lo_r <= NATIVE_MAX[15:8];
      cyl_hi_r <= NATIVE_MAX[23:16];
      dh_r <= {dh_r[7:4], NATIVE_MAX[27:24]};
    end else if (wr_take) begin
      unique case (avs_address_i)
        OFS_FEATURE: feat_r <= avs_writedata_i[7:0];
        OFS_SECCNT: seccnt_r <= avs_writedata_i[7:0];
        OFS_SECNUM: secnum_r <= avs_writedata_i[7:0];
        OFS_CYL_LO: cyl_lo_r <= avs_writedata_i[7:0];
        OFS_CYL_HI: cyl_hi_r <= avs_writedata_i[7:0];
        OFS_DRVHEAD: dh_r <= avs_writedata_i[7:0];
        default: ;
      endcase
    end
  end

  // only a directly preceding read-native opens a set-max address change
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      prev_native_r <= 1'b0;
    end else if (hw_reset_i) begin
      prev_native_r <= 1'b0;
    end else if (busy) begin
      prev_native_r <= is_native;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // limit storage; nv copy models the flash-held limit, which on
  // power-on can only come back as the native size here
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      max_r <= NATIVE_MAX;
      nv_max_r <= NATIVE_MAX;
      max_lba_o <= NATIVE_MAX;
    end else begin
      max_lba_o <= max_r; // host view trails the limit by a cycle
      if (hw_reset_i) begin
        max_r <= nv_max_r;
      end else if (busy && is_setmax && feat_r == SMAX_ADDRESS && max_ok) begin
        max_r <= req_lba;
        if (keep_limit) begin
          nv_max_r <= req_lba;
        end
      end
    end
  end

  // one-shot guard against the first nonvolatile set after reset
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      nv_block_r <= 1'b1;
    end else if (hw_reset_i) begin
      nv_block_r <= 1'b1;
    end else if (busy && is_setmax && feat_r == SMAX_ADDRESS &&
                 keep_limit && prev_native_r) begin
      nv_block_r <= 1'b0;
    end
  end

  // password, lock and freeze state of the limit
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      pw_r <= RST_PW;
      locked_r <= 1'b0;
      frozen_r <= 1'b0;
    end else if (hw_reset_i) begin
      locked_r <= 1'b0;
      frozen_r <= 1'b0;
    end else if (busy && is_setmax && !abort_nxt) begin
      unique case (feat_r)
        SMAX_SET_PW: pw_r <= {cyl_hi_r, cyl_lo_r};
        SMAX_LOCK: locked_r <= 1'b1;
        SMAX_UNLOCK: locked_r <= 1'b0;
        SMAX_FREEZE: frozen_r <= 1'b1;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // multiple mode; off from power-on until a good count arrives
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      mult_en_o <= 1'b0;
      mult_cnt_o <= RST_MULT_CNT;
    end else if (busy && is_mult) begin
      if (mult_ok) begin
        mult_en_o <= 1'b1;
        mult_cnt_o <= seccnt_r;
      end else begin
        mult_en_o <= 1'b0;
      end
    end
  end

  // sleep entry and wake on the next command
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      sleep_o <= 1'b0;
    end else if (busy) begin
      sleep_o <= is_sleep;
    end else if (cmd_take) begin
      sleep_o <= 1'b0;
    end
  end

  // smart request handed to the monitoring engine
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      smart_req_o <= 1'b0;
      smart_feature_o <= RST_TF;
    end else begin
      smart_req_o <= busy && is_smart && smart_sig;
      if (busy && is_smart && smart_sig) begin
        smart_feature_o <= feat_r;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read data, latched in the wait cycle; unmapped reads give zero
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      avs_readdata_o <= 32'h00000000;
    end else if (arm && avs_read_i) begin
      avs_readdata_o <= 32'h00000000;
      unique case (avs_address_i)
        OFS_FEATURE: avs_readdata_o[7:0] <= feat_r;
        OFS_SECCNT: avs_readdata_o[7:0] <= seccnt_r;
        OFS_SECNUM: avs_readdata_o[7:0] <= secnum_r;
        OFS_CYL_LO: avs_readdata_o[7:0] <= cyl_lo_r;
        OFS_CYL_HI: avs_readdata_o[7:0] <= cyl_hi_r;
        OFS_DRVHEAD: avs_readdata_o[7:0] <= dh_r;
        OFS_COMMAND: avs_readdata_o[7:0] <= cmd_r;
        OFS_STATUS: begin
          avs_readdata_o[ST_BSY_BIT] <= busy;
          avs_readdata_o[ST_DRDY_BIT] <= !busy;
          avs_readdata_o[ST_SLEEP_BIT] <= sleep_o;
          avs_readdata_o[ST_ERR_BIT] <= abrt_r;
        end
        OFS_ERROR: avs_readdata_o[ER_ABRT_BIT] <= abrt_r;
        OFS_MAX_LBA: avs_readdata_o[27:0] <= max_r;
        OFS_MULT: begin
          avs_readdata_o[7:0] <= mult_cnt_o;
          avs_readdata_o[MULT_EN_BIT] <= mult_en_o;
        end
        OFS_IDENT82: avs_readdata_o[IDENT82_SMART_BIT] <= 1'b1;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);

  a_cmd_busy_pulse: assert property (cmd_take |=> busy ##1 !busy)
    else $error("busy not one cycle after command");
  a_cmd_irq: assert property (busy |=> irq_o && !busy)
    else $error("no completion interrupt after command");
  a_setmax_prereq: assert property (busy && is_setmax &&
      feat_r == SMAX_ADDRESS && !prev_native_r |=> abrt_r)
    else $error("set-max without read-native not aborted");
  a_setmax_value: assert property (busy && is_setmax &&
      feat_r == SMAX_ADDRESS && max_ok && !hw_reset_i
      |=> max_lba_o == $past(max_lba_o) ##1 max_lba_o == $past(req_lba, 2))
    else $error("maximum not taken from task file");
  a_keep_limit: assert property (busy && is_setmax &&
      feat_r == SMAX_ADDRESS && max_ok && keep_limit && !hw_reset_i
      |=> nv_max_r == max_r)
    else $error("nonvolatile limit not stored");
  a_hwreset_revert: assert property (hw_reset_i
      |=> max_r == $past(nv_max_r))
    else $error("limit not reverted on hardware reset");
  a_feat_reserved: assert property (busy && is_setmax &&
      feat_r > SMAX_FREEZE |=> abrt_r)
    else $error("reserved feature not aborted");
  a_nv_after_reset: assert property (busy && is_setmax &&
      feat_r == SMAX_ADDRESS && keep_limit && nv_block_r && !hw_reset_i
      |=> abrt_r && max_r == $past(max_r))
    else $error("first nonvolatile set-max not aborted");
  a_mult_store: assert property (busy && is_mult && mult_ok
      |=> mult_en_o && mult_cnt_o == $past(seccnt_r) && !abrt_r)
    else $error("good block count not stored");
  a_mult_bad: assert property (busy && is_mult && !mult_ok
      |=> !mult_en_o && abrt_r == !$past(mult_zero))
    else $error("bad or zero block count mishandled");
  a_sleep_cycle: assert property (busy && is_sleep
      |=> sleep_o && irq_o)
    else $error("sleep not entered");
  a_sleep_wake: assert property (sleep_o && cmd_take
      |=> !sleep_o ##1 sleep_o == $past(is_sleep))
    else $error("drive did not wake");
  a_smart_sig: assert property (busy && is_smart
      |=> smart_req_o == !abrt_r)
    else $error("smart signature check wrong");

  c_sleep: cover property (busy && is_sleep ##1 sleep_o);
  c_mult_on: cover property (busy && is_mult && mult_ok);
  c_setmax_ok: cover property (busy && is_setmax && max_ok);
  c_smart: cover property (smart_req_o);

endmodule

// ==== tb/acsm_host.sv ====
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////
// host adapter model: an avalon master issuing task-file accesses
module acsm_host
  import acsm_pkg::*;
(
  input wire logic sys_clk_i, // system clock
  input wire logic waitrequest_i, // slave wait request
  input wire logic [31:0] readdata_i, // slave read data
  output logic [ADDR_W-1:0] address_o, // byte address
  output logic read_o, // read strobe
  output logic write_o, // write strobe
  output logic [31:0] writedata_o // write data
);
  // idle bus at time zero
  initial begin
    address_o = 6'h3f;
    read_o = 1'b0;
    write_o = 1'b0;
    writedata_o = 32'h0;
  end

  ////////////////////////////////////////////////////////////////////////
  // one request, held until waitrequest is seen low at an edge
  task automatic xfer(input logic rnw, input logic [ADDR_W-1:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    @(posedge sys_clk_i);
    address_o <= a;
    writedata_o <= d;
    read_o <= rnw;
    write_o <= ~rnw;
    @(posedge sys_clk_i);
    while (waitrequest_i !== 1'b0) @(posedge sys_clk_i);
    q = readdata_i;
    read_o <= 1'b0;
    write_o <= 1'b0;
    // released lines flip so a stale value is never mistaken for data
    address_o <= ~a;
    writedata_o <= ~d;
  endtask

  // write access
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b0, a, d, q);
  endtask

  // read access
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] q);
    xfer(1'b1, a, 32'h0, q);
  endtask
endmodule

// ==== tb/acsm_top_tb.sv ====
`timescale 1ns/1ps
module acsm_top_tb
  import acsm_pkg::*;
;
  localparam logic [27:0] NATIVE = 28'h2ffffff;
  localparam int MAXM = 16;
  localparam logic [27:0] SIG = {4'h0, SMART_SIG_HI, SMART_SIG_LO, 8'h00};
  logic sys_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic hw_reset_i = 1'b0;
  logic [ADDR_W-1:0] adr;
  logic rd_s, wr_s, wait_s, irq, sleep, mult_en, smart_req;
  logic [31:0] wdat, rdat, q;
  logic [7:0] mult_cnt, smart_fe;
  logic [27:0] max_lba;
  logic [7:0] mc [6] = '{8'h04, 8'h03, 8'h10, 8'h20, 8'h01, 8'h00};
  // expected acceptance of each count above for a 16-sector buffer
  logic mok [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
  int n_fail = 0;
  int samples_checked = 0;
  int irq_n = 0;
  int smart_n = 0;
  int cyc = 0;

  ////////////////////////////////////////////////////////////////////////
  acsm_top #(.NATIVE_MAX(NATIVE), .MAX_MULT(MAXM)) i_acsm_top (
    .sys_clk_i(sys_clk_i), .reset_i(reset_i), .hw_reset_i(hw_reset_i),
    .avs_address_i(adr), .avs_read_i(rd_s), .avs_write_i(wr_s),
    .avs_writedata_i(wdat), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wait_s), .irq_o(irq), .sleep_o(sleep),
    .mult_en_o(mult_en), .mult_cnt_o(mult_cnt), .max_lba_o(max_lba),
    .smart_req_o(smart_req), .smart_feature_o(smart_fe));

  acsm_host i_acsm_host (
    .sys_clk_i(sys_clk_i), .waitrequest_i(wait_s), .readdata_i(rdat),
    .address_o(adr), .read_o(rd_s), .write_o(wr_s), .writedata_o(wdat));

  always #50 sys_clk_i = ~sys_clk_i;

  // pulse counters and hang guard; whole run needs under a thousand cycles
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (irq === 1'b1) irq_n <= irq_n + 1;
    if (smart_req === 1'b1) smart_n <= smart_n + 1;
    if (cyc == 20000) begin
      n_fail = n_fail + 1;
      stop_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // masked register read compare
  task automatic rdc(input logic [ADDR_W-1:0] a, input logic [31:0] m,
                     input logic [31:0] e, input string nm);
    i_acsm_host.rd(a, q);
    chk(nm, q & m, e);
  endtask

  // drive/head carries lba bit, device bit zero, top address nibble
  task automatic set_tf(input logic [7:0] fe, input logic [7:0] sc,
                        input logic [27:0] v, input logic lba);
    logic [7:0] dh;
    dh = {1'b1, lba, 2'b10, v[27:24]};
    i_acsm_host.wr(OFS_FEATURE, {24'h0, fe});
    i_acsm_host.wr(OFS_SECCNT, {24'h0, sc});
    i_acsm_host.wr(OFS_SECNUM, {24'h0, v[7:0]});
    i_acsm_host.wr(OFS_CYL_LO, {24'h0, v[15:8]});
    i_acsm_host.wr(OFS_CYL_HI, {24'h0, v[23:16]});
    i_acsm_host.wr(OFS_DRVHEAD, {24'h0, dh});
  endtask

  // command write, then abort flag and completion pulse
  task automatic cmd(input logic [7:0] c, input logic ab);
    int n0;
    n0 = irq_n;
    i_acsm_host.wr(OFS_COMMAND, {24'h0, c});
    i_acsm_host.rd(OFS_ERROR, q);
    chk("abort", {31'h0, q[ER_ABRT_BIT]}, {31'h0, ab});
    chk("irq count", 32'(irq_n - n0), 32'd1);
  endtask

  task automatic setmax(input logic [27:0] v, input logic keep,
                        input logic ab);
    cmd(CMD_READ_NATIVE, 1'b0);
    set_tf(SMAX_ADDRESS, {7'h0, keep}, v, 1'b1);
    cmd(CMD_SET_MAX, ab);
  endtask

  task automatic sub(input logic [7:0] fe, input logic [27:0] v,
                     input logic ab);
    set_tf(fe, 8'h00, v, 1'b1);
    cmd(CMD_SET_MAX, ab);
  endtask

  task automatic hw_pulse();
    @(posedge sys_clk_i);
    hw_reset_i <= 1'b1;
    @(posedge sys_clk_i);
    hw_reset_i <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    logic ok, ab;
    logic [7:0] c;
    int n0;
    repeat (10) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    @(posedge sys_clk_i);
    // power-on state
    chk("max_lba", {4'h0, max_lba}, {4'h0, NATIVE});
    chk("mult_en", {31'h0, mult_en}, 32'h0);
    chk("sleep", {31'h0, sleep}, 32'h0);
    rdc(OFS_IDENT82, 32'h1, 32'h1, "ident82");
    rdc(6'h3c, 32'hffffffff, 32'h0, "unmapped");
    rdc(OFS_STATUS, 32'hc1, 32'h40, "status");
    // set-max with no read-native before it
    set_tf(SMAX_ADDRESS, 8'h00, 28'h0001000, 1'b1);
    cmd(CMD_SET_MAX, 1'b1);
    rdc(OFS_STATUS, 32'h01, 32'h01, "status err");
    cmd(CMD_READ_NATIVE, 1'b0);
    rdc(OFS_SECNUM, 32'hff, {24'h0, NATIVE[7:0]}, "native lo");
    rdc(OFS_DRVHEAD, 32'h0f, {28'h0, NATIVE[27:24]}, "native hi");
    // first kept limit after reset is refused, the next one sticks
    setmax(28'h1a2b3c4, 1'b1, 1'b1);
    chk("max_lba", {4'h0, max_lba}, {4'h0, NATIVE});
    setmax(28'h1a2b3c4, 1'b1, 1'b0);
    chk("max_lba", {4'h0, max_lba}, 32'h01a2b3c4);
    rdc(OFS_MAX_LBA, 32'h0fffffff, 32'h01a2b3c4, "max reg");
    // shutdown: volatile native limit, reset brings back the kept one
    setmax(NATIVE, 1'b0, 1'b0);
    chk("max_lba", {4'h0, max_lba}, {4'h0, NATIVE});
    hw_pulse();
    chk("max_lba", {4'h0, max_lba}, 32'h01a2b3c4);
    setmax(28'h0000100, 1'b1, 1'b1);
    // boot: native first, then the file-system size
    setmax(NATIVE, 1'b0, 1'b0);
    setmax(28'h0000200, 1'b0, 1'b0);
    chk("max_lba", {4'h0, max_lba}, 32'h00000200);
    // password, lock, unlock, freeze, reserved codes
    sub(SMAX_SET_PW, 28'h05a3c00, 1'b0);
    sub(SMAX_LOCK, 28'h0, 1'b0);
    setmax(28'h0000300, 1'b0, 1'b1);
    sub(SMAX_UNLOCK, 28'h0123400, 1'b1);
    sub(SMAX_UNLOCK, 28'h05a3c00, 1'b0);
    setmax(28'h0000300, 1'b0, 1'b0);
    sub(SMAX_FREEZE, 28'h0, 1'b0);
    sub(SMAX_SET_PW, 28'h05a3c00, 1'b1);
    sub(8'h05, 28'h0, 1'b1);
    sub(8'hff, 28'h0, 1'b1);
    hw_pulse();
    // block counts: power of two up to the limit, zero disables quietly
    foreach (mc[i]) begin
      c = mc[i];
      ok = mok[i];
      ab = (c != 0) && !ok;
      set_tf(8'h00, c, 28'h0, 1'b1);
      cmd(CMD_SET_MULT, ab);
      chk("mult_en", {31'h0, mult_en}, {31'h0, ok});
      if (ok) chk("mult_cnt", {24'h0, mult_cnt}, {24'h0, c});
      rdc(OFS_MULT, 32'h100, {23'h0, ok, 8'h0}, "mult reg");
    end
    // sleep entry by both codes, wake by any other command
    cmd(CMD_SLEEP_A, 1'b0);
    chk("sleep", {31'h0, sleep}, 32'h1);
    rdc(OFS_STATUS, 32'h20, 32'h20, "sleep bit");
    cmd(CMD_SET_MULT, 1'b0);
    chk("sleep", {31'h0, sleep}, 32'h0);
    cmd(CMD_SLEEP_B, 1'b0);
    chk("sleep", {31'h0, sleep}, 32'h1);
    cmd(CMD_READ_NATIVE, 1'b0);
    chk("sleep", {31'h0, sleep}, 32'h0);
    // smart: good signature, bad cylinder low, bad head bits
    for (int i = 0; i < 3; i++) begin
      n0 = smart_n;
      set_tf(8'hd0 + 8'(i), 8'h00, (i == 1) ? SIG ^ 28'h100 : SIG, i != 2);
      cmd(CMD_SMART, i != 0);
      chk("smart req", 32'(smart_n - n0), (i == 0) ? 1 : 0);
      if (i == 0) chk("smart fe", {24'h0, smart_fe}, 32'hd0);
    end
    stop_test();
  end
endmodule
